// ### verilog/cgd_cfg.svh
// Constants for the clip guardband determination block.
`ifndef CGD_CFG_SVH
`define CGD_CFG_SVH
`define CGD_REG_CTRL 12'h000
`define CGD_REG_TBLPTR 12'h004
`define CGD_REG_STATUS 12'h008
`define CGD_REG_ACCCNT 12'h00C
`define CGD_REG_REJCNT 12'h010
`define CGD_REG_CLPCNT 12'h014
`define CGD_CTRL_VPEN 0
`define CGD_CTRL_GBEN 1
`define CGD_CTRL_ROUTE_LO 2
`define CGD_CTRL_UCF_LO 8
`define CGD_CTRL_RESET 32'h0000_0003
`define CGD_NUM_VP 16
`define CGD_HDR_BITS 256
`endif

// ### verilog/cgd_pkg.sv
// Types for the clip guardband determination block.
`default_nettype none
package cgd_pkg;
   typedef enum logic [1:0] {CGD_ROUTE_NORMAL = 2'h0, CGD_ROUTE_ALL = 2'h1, CGD_ROUTE_NONREJ = 2'h2} cgd_route_t;
   typedef enum logic [1:0] {CGD_OUT_REJECT = 2'h0, CGD_OUT_ACCEPT = 2'h1, CGD_OUT_CLIP = 2'h2} cgd_outcome_t;
   // Per-vertex header fields used by the test: 32-bit signed fixed point positions.
   typedef struct packed {
      logic [31:0] x;
      logic [31:0] y;
      logic [31:0] z;
      logic [31:0] rhw;
      logic [7:0] ucf;
      logic [3:0] vpIndex;
   } cgd_vhdr_t;
   // Guardband limits, one set per viewport.
   typedef struct packed {
      logic [31:0] xmin;
      logic [31:0] xmax;
      logic [31:0] ymin;
      logic [31:0] ymax;
   } cgd_gb_t;
   // Vertex entry arriving from the geometry shader stage.
   typedef struct packed {
      logic [15:0] handle;
      logic [1:0] nVert;
      logic last;
      logic fromThread;
   } cgd_vin_t;
endpackage
`default_nettype wire

// ### verilog/cgd_gb_mem.sv
// Guardband parameter cache, one entry per viewport, registered read.
`timescale 1ns/1ps
`default_nettype none
`include "cgd_cfg.svh"
module cgd_gb_mem #(
   parameter int DEPTH = `CGD_NUM_VP
) (
   input wire logic clk, // clock
   input wire logic wrEn, // write strobe
   input wire logic [3:0] wrAddr, // write index
   input wire cgd_pkg::cgd_gb_t wrData, // write data
   input wire logic [3:0] rdAddr, // read index
   output cgd_pkg::cgd_gb_t rdData // registered read data
);
   cgd_pkg::cgd_gb_t mem [DEPTH];
   always_ff @(posedge clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
   end
   always_ff @(posedge clk) begin
      rdData <= mem[rdAddr];
   end
endmodule
`default_nettype wire

// ### verilog/cgd_top.sv
// Guardband-aware clip test and object decision for the clip stage.
`timescale 1ns/1ps
`default_nettype none
`include "cgd_cfg.svh"
module cgd_top (
   input wire logic clk, // 10 MHz clock
   input wire logic sys_rst, // synchronous reset, active high
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [11:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error
   input wire logic vinValid, // vertex entry valid
   output logic vinReady, // vertex entry taken
   input wire cgd_pkg::cgd_vin_t vinData, // vertex entry
   output logic hdrReq, // header readback request
   output logic [15:0] hdrHandle, // handle being read back
   input wire logic hdrValid, // readback data valid
   input wire cgd_pkg::cgd_vhdr_t hdrData, // readback header fields
   output logic memReq, // guardband table fetch request
   output logic [31:0] memAddr, // guardband table fetch address
   input wire logic memValid, // fetch data valid
   input wire cgd_pkg::cgd_gb_t memData, // fetched guardband set
   output logic outValid, // decision valid, one cycle
   output cgd_pkg::cgd_outcome_t outKind, // decision
   output logic [47:0] outHandles, // handles of the object
   output logic releaseValid // input vertices released to clip thread
);
   typedef enum logic [5:0] {
      S_IDLE = 6'b000001, S_RB = 6'b000010, S_FETCH = 6'b000100,
      S_TEST = 6'b001000, S_DECIDE = 6'b010000, S_WAIT = 6'b100000
   } cgd_state_t;

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   logic [31:0] ctrl_q;
   logic [31:0] tblPtr_q;
   logic [15:0] gbLoaded_q;
   logic [31:0] accCnt_q, rejCnt_q, clpCnt_q;
   logic apbWr;
   logic mapped;
   assign apbWr = psel && penable && pwrite;
   assign pready = 1'b1;
   always_comb begin
      mapped = 1'b1;
      if (paddr == `CGD_REG_CTRL) begin
         prdata = ctrl_q;
      end else if (paddr == `CGD_REG_TBLPTR) begin
         prdata = tblPtr_q;
      end else if (paddr == `CGD_REG_STATUS) begin
         prdata = {16'h0000, gbLoaded_q};
      end else if (paddr == `CGD_REG_ACCCNT) begin
         prdata = accCnt_q;
      end else if (paddr == `CGD_REG_REJCNT) begin
         prdata = rejCnt_q;
      end else if (paddr == `CGD_REG_CLPCNT) begin
         prdata = clpCnt_q;
      end else begin
         prdata = 32'h0000_0000;
         mapped = 1'b0;
      end
   end
   assign pslverr = psel && penable && !mapped;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_q <= `CGD_CTRL_RESET;
      end else if (apbWr && paddr == `CGD_REG_CTRL) begin
         ctrl_q <= pwdata;
      end
   end
   // Writing the pointer invalidates the cached sets so they are refetched.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tblPtr_q <= 32'h0000_0000;
      end else if (apbWr && paddr == `CGD_REG_TBLPTR) begin
         tblPtr_q <= pwdata;
      end
   end

   logic vpEn, gbEn;
   cgd_pkg::cgd_route_t route;
   logic [7:0] ucfMask;
   assign vpEn = ctrl_q[`CGD_CTRL_VPEN];
   assign gbEn = ctrl_q[`CGD_CTRL_GBEN];
   assign route = cgd_pkg::cgd_route_t'(ctrl_q[`CGD_CTRL_ROUTE_LO +: 2]);
   assign ucfMask = ctrl_q[`CGD_CTRL_UCF_LO +: 8];

   // ----------------------------------------------------------------
   // Outcode arithmetic
   // ----------------------------------------------------------------
   // Bits: 0..3 viewport L R B T, 4..7 guardband L R B T, 8 Z, 9 negw, 10..17 ucf.
   function automatic logic [17:0] vertCode(input cgd_pkg::cgd_vhdr_t h, input cgd_pkg::cgd_gb_t g,
                                            input logic vp, input logic gb, input logic [7:0] m);
      logic neg;
      logic [3:0] v, b;
      logic [31:0] one, mone;
      neg = h.rhw[31];
      one = 32'h0001_0000;
      mone = 32'hFFFF_0000;
      v = 4'h0;
      b = 4'h0;
      if (vp) begin
         v = neg ? {$signed(h.y) < $signed(one), $signed(h.y) > $signed(mone),
                    $signed(h.x) < $signed(one), $signed(h.x) > $signed(mone)}
                 : {$signed(h.y) > $signed(one), $signed(h.y) < $signed(mone),
                    $signed(h.x) > $signed(one), $signed(h.x) < $signed(mone)};
      end
      if (gb) begin
         // Each edge has its own limit, so the band may sit inside the viewport.
         b = neg ? {$signed(h.y) < $signed(g.ymax), $signed(h.y) > $signed(g.ymin),
                    $signed(h.x) < $signed(g.xmax), $signed(h.x) > $signed(g.xmin)}
                 : {$signed(h.y) > $signed(g.ymax), $signed(h.y) < $signed(g.ymin),
                    $signed(h.x) > $signed(g.xmax), $signed(h.x) < $signed(g.xmin)};
      end
      if (vp && !gb) begin
         b = v;
      end else if (!vp && gb) begin
         v = b;
      end
      vertCode = {h.ucf & m, neg, neg ? ($signed(h.z) > 0) : ($signed(h.z) < 0), b, v};
   endfunction

   // ----------------------------------------------------------------
   // Object sequencing
   // ----------------------------------------------------------------
   cgd_state_t state_q;
   logic [1:0] nVert_q, idx_q;
   logic [47:0] handles_q;
   logic [17:0] andCode_q, orCode_q;
   logic [3:0] vpIdx_q;
   cgd_pkg::cgd_vhdr_t hdr_q;
   cgd_pkg::cgd_gb_t gbRd;
   logic thread_q;
   logic [17:0] code;
   logic rej, acc;
   cgd_pkg::cgd_outcome_t kind;

   cgd_gb_mem #(.DEPTH(`CGD_NUM_VP)) u_mem (
      .clk(clk),
      .wrEn(state_q == S_FETCH && memValid),
      .wrAddr(vpIdx_q),
      .wrData(memData),
      .rdAddr(vpIdx_q),
      .rdData(gbRd)
   );

   assign code = vertCode(hdr_q, gbRd, vpEn, gbEn, ucfMask);
   // Triangles, rectangle lists and non-wide lines share one path; only the vertex count differs.
   assign rej = |andCode_q[3:0] || |andCode_q[17:8] && !andCode_q[9] || andCode_q[9];
   assign acc = ~|orCode_q[17:4];
   always_comb begin
      if (thread_q) begin
         kind = cgd_pkg::CGD_OUT_ACCEPT;
      end else if (route == cgd_pkg::CGD_ROUTE_ALL) begin
         kind = cgd_pkg::CGD_OUT_CLIP;
      end else if (rej) begin
         kind = cgd_pkg::CGD_OUT_REJECT;
      end else if (acc && route != cgd_pkg::CGD_ROUTE_NONREJ) begin
         kind = cgd_pkg::CGD_OUT_ACCEPT;
      end else begin
         kind = cgd_pkg::CGD_OUT_CLIP;
      end
   end

   assign vinReady = state_q == S_IDLE;
   assign hdrReq = state_q == S_RB;
   assign hdrHandle = handles_q[16*idx_q +: 16];
   assign memReq = state_q == S_FETCH;
   assign memAddr = tblPtr_q + {24'h000000, vpIdx_q, 4'h0};

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q <= S_IDLE;
         nVert_q <= 2'h0;
         idx_q <= 2'h0;
         handles_q <= 48'h0;
         thread_q <= 1'b0;
         vpIdx_q <= 4'h0;
         hdr_q <= '0;
         andCode_q <= 18'h3FFFF;
         orCode_q <= 18'h0;
      end else begin
         case (state_q)
            S_IDLE: begin
               if (vinValid) begin
                  handles_q[16*idx_q +: 16] <= vinData.handle;
                  nVert_q <= vinData.nVert;
                  thread_q <= vinData.fromThread;
                  if (vinData.last || idx_q + 2'h1 == vinData.nVert) begin
                     idx_q <= 2'h0;
                     andCode_q <= 18'h3FFFF;
                     orCode_q <= 18'h0;
                     state_q <= S_RB;
                  end else begin
                     idx_q <= idx_q + 2'h1;
                  end
               end
            end
            S_RB: begin
               if (hdrValid) begin
                  hdr_q <= hdrData;
                  vpIdx_q <= hdrData.vpIndex;
                  state_q <= gbLoaded_q[hdrData.vpIndex] ? S_WAIT : S_FETCH;
               end
            end
            S_FETCH: begin
               if (memValid) begin
                  state_q <= S_WAIT;
               end
            end
            S_WAIT: begin
               state_q <= S_TEST; // memory read data settles
            end
            S_TEST: begin
               andCode_q <= andCode_q & code;
               orCode_q <= orCode_q | code;
               if (idx_q + 2'h1 >= nVert_q) begin
                  state_q <= S_DECIDE;
               end else begin
                  idx_q <= idx_q + 2'h1;
                  state_q <= S_RB;
               end
            end
            S_DECIDE: begin
               idx_q <= 2'h0;
               state_q <= S_IDLE;
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // A fetch landing in the same cycle as a pointer write keeps its set marked valid, so software
   // should move the pointer only while no object is in flight.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         gbLoaded_q <= 16'h0000;
      end else begin
         if (apbWr && paddr == `CGD_REG_TBLPTR) begin
            gbLoaded_q <= 16'h0000;
         end
         if (state_q == S_FETCH && memValid) begin
            gbLoaded_q[vpIdx_q] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         outValid <= 1'b0;
         outKind <= cgd_pkg::CGD_OUT_REJECT;
         outHandles <= 48'h0;
         releaseValid <= 1'b0;
      end else begin
         outValid <= state_q == S_DECIDE;
         releaseValid <= state_q == S_DECIDE && kind == cgd_pkg::CGD_OUT_CLIP;
         if (state_q == S_DECIDE) begin
            outKind <= kind;
            outHandles <= handles_q;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         accCnt_q <= 32'h0;
         rejCnt_q <= 32'h0;
         clpCnt_q <= 32'h0;
      end else if (state_q == S_DECIDE) begin
         if (kind == cgd_pkg::CGD_OUT_ACCEPT) begin
            accCnt_q <= accCnt_q + 32'h1;
         end else if (kind == cgd_pkg::CGD_OUT_REJECT) begin
            rejCnt_q <= rejCnt_q + 32'h1;
         end else begin
            clpCnt_q <= clpCnt_q + 32'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   one_outcome_a: assert property (@(posedge clk) disable iff (sys_rst)
      outValid |-> outKind inside {cgd_pkg::CGD_OUT_REJECT, cgd_pkg::CGD_OUT_ACCEPT, cgd_pkg::CGD_OUT_CLIP})
      else $error("bad outcome");
   clip_release_a: assert property (@(posedge clk) disable iff (sys_rst)
      releaseValid |-> outValid && outKind == cgd_pkg::CGD_OUT_CLIP)
      else $error("release without clip");
   route_all_a: assert property (@(posedge clk) disable iff (sys_rst)
      state_q == S_DECIDE && !thread_q && route == cgd_pkg::CGD_ROUTE_ALL |=> outKind == cgd_pkg::CGD_OUT_CLIP)
      else $error("route all ignored");
   reject_first_a: assert property (@(posedge clk) disable iff (sys_rst)
      state_q == S_DECIDE && rej && !thread_q && route != cgd_pkg::CGD_ROUTE_ALL
      |=> outKind == cgd_pkg::CGD_OUT_REJECT)
      else $error("reject not first");
   band_accept_a: assert property (@(posedge clk) disable iff (sys_rst)
      state_q == S_DECIDE && !rej && acc && route == cgd_pkg::CGD_ROUTE_NORMAL
      |=> outKind == cgd_pkg::CGD_OUT_ACCEPT)
      else $error("band accept missed");
   readback_first_a: assert property (@(posedge clk) disable iff (sys_rst)
      state_q == S_TEST |-> $past(state_q, 1) == S_WAIT)
      else $error("test without readback");
   fetch_ptr_a: assert property (@(posedge clk) disable iff (sys_rst)
      memReq |-> memAddr == tblPtr_q + {24'h000000, vpIdx_q, 4'h0} && !gbLoaded_q[vpIdx_q])
      else $error("fetch address wrong");
   copy_codes_a: assert property (@(posedge clk) disable iff (sys_rst)
      vpEn != gbEn |-> code[3:0] == code[7:4])
      else $error("outcodes not copied");
   negw_code_a: assert property (@(posedge clk) disable iff (sys_rst)
      code[9] == hdr_q.rhw[31])
      else $error("negative w code wrong");
endmodule
`default_nettype wire

// ### tb/cgd_mem_model.sv
// Behavioural model of the vertex buffer readback port and the guardband table memory.
`timescale 1ns/1ps
`default_nettype none
module cgd_mem_model (
   input wire logic clk, // clock
   input wire logic sys_rst, // synchronous reset
   input wire logic slow, // stretch every answer by five cycles
   input wire logic hdrReq, // readback request
   input wire logic [15:0] hdrHandle, // handle read back
   output logic hdrValid, // readback valid, one cycle
   output cgd_pkg::cgd_vhdr_t hdrData, // header fields
   input wire logic memReq, // table fetch request
   input wire logic [31:0] memAddr, // fetch address
   output logic memValid, // fetch valid, one cycle
   output cgd_pkg::cgd_gb_t memData // guardband set
);
   cgd_pkg::cgd_vhdr_t hdrTab [16];
   cgd_pkg::cgd_gb_t gbTab [16];
   logic [2:0] hCnt = 3'h0;
   logic [2:0] mCnt = 3'h0;
   int reads = 0;
   initial hdrValid = 1'b0;
   initial memValid = 1'b0;
   initial hdrData = '0;
   initial memData = '0;
   // Released data lines are inverted so a stale value is never mistaken for a fresh answer.
   always @(posedge clk) begin
      if (sys_rst || hdrValid || !hdrReq) begin
         hdrValid <= 1'b0;
         hCnt <= 3'h0;
         if (hdrValid) hdrData <= ~hdrData;
      end else if (hCnt >= (slow ? 3'h5 : 3'h0)) begin
         hdrValid <= 1'b1;
         hdrData <= hdrTab[hdrHandle[3:0]];
         reads <= reads + 1;
      end else begin
         hCnt <= hCnt + 3'h1;
      end
   end
   // The table base is 256-byte aligned, so bits 7:4 of the address pick the viewport set.
   always @(posedge clk) begin
      if (sys_rst || memValid || !memReq) begin
         memValid <= 1'b0;
         mCnt <= 3'h0;
         if (memValid) memData <= ~memData;
      end else if (mCnt >= (slow ? 3'h5 : 3'h0)) begin
         memValid <= 1'b1;
         memData <= gbTab[memAddr[7:4]];
      end else begin
         mCnt <= mCnt + 3'h1;
      end
   end
endmodule
`default_nettype wire

// ### tb/test_clip_guardband_determination.sv
// Self-checking bench for the clip guardband determination block.
`timescale 1ns/1ps
`default_nettype none
`include "cgd_cfg.svh"
module test_clip_guardband_determination;
   localparam logic [31:0] I0 = 32'h0000_8000;
   localparam logic [31:0] O1 = 32'h0001_8000;
   localparam logic [31:0] F3 = 32'h0003_0000;
   localparam logic [31:0] M8 = 32'h0000_CCCC;
   localparam logic [31:0] W1 = 32'h0001_0000;
   localparam logic [31:0] WN = 32'hFFFF_0000;
   localparam logic [31:0] TBL = 32'h0000_1000;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic vinValid = 1'b0, vinReady, hdrReq, hdrValid, memReq, memValid, outValid, releaseValid;
   cgd_pkg::cgd_vin_t vinData = '0;
   cgd_pkg::cgd_vhdr_t hdrData;
   cgd_pkg::cgd_gb_t memData;
   cgd_pkg::cgd_outcome_t outKind, gotKind;
   logic [15:0] hdrHandle, hnd = 16'h0100;
   logic [31:0] memAddr, rdv;
   logic [47:0] outHandles, gotHnd;
   logic slow = 1'b0, got = 1'b0, gotRel, err;
   int fails = 0, cmp_count = 0, cycles = 0, nA = 0, nR = 0, nC = 0, nV = 0;
   always #50 clk = ~clk;
   cgd_top u_cgd_top (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .vinValid(vinValid), .vinReady(vinReady), .vinData(vinData), .hdrReq(hdrReq), .hdrHandle(hdrHandle),
      .hdrValid(hdrValid), .hdrData(hdrData), .memReq(memReq), .memAddr(memAddr), .memValid(memValid),
      .memData(memData), .outValid(outValid), .outKind(outKind), .outHandles(outHandles),
      .releaseValid(releaseValid));
   cgd_mem_model u_cgd_mem_model (.clk(clk), .sys_rst(sys_rst), .slow(slow), .hdrReq(hdrReq),
      .hdrHandle(hdrHandle), .hdrValid(hdrValid), .hdrData(hdrData), .memReq(memReq), .memAddr(memAddr),
      .memValid(memValid), .memData(memData));
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic ee);
      apb(1'b0, a, 32'h0);
      check(rdv, e);
      check(err, ee);
   endtask
   // Sends one object vertex by vertex, holding valid up between vertices, then checks its single outcome.
   task automatic obj(input logic [1:0] n, input logic [3:0] vp, input logic [31:0] x0, x1, x2,
                      input logic [31:0] w, input logic [7:0] uf, input logic th, input cgd_pkg::cgd_outcome_t e);
      logic [31:0] xs [3];
      logic [47:0] h, m;
      int t;
      xs = '{x0, x1, x2};
      h = '0;
      m = '0;
      got <= 1'b0;
      for (int i = 0; i < n; i++) begin
         u_cgd_mem_model.hdrTab[hnd[3:0]] = {xs[i], 32'h0, I0, w, uf, vp};
         h[16*i +: 16] = hnd;
         m[16*i +: 16] = 16'hFFFF;
         vinValid <= 1'b1;
         vinData <= {hnd, n, i == n - 1, th};
         hnd++;
         nV++;
         do @(posedge clk); while (vinReady !== 1'b1);
      end
      vinValid <= 1'b0;
      t = 0;
      while (got !== 1'b1 && t < 300) begin
         @(posedge clk);
         t++;
      end
      check(got, 1'b1);
      check(gotKind, e);
      check(gotHnd & m, h);
      check(gotRel, e == cgd_pkg::CGD_OUT_CLIP);
      if (e == cgd_pkg::CGD_OUT_ACCEPT) nA++;
      else if (e == cgd_pkg::CGD_OUT_REJECT) nR++;
      else nC++;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (outValid === 1'b1) begin
         gotKind <= outKind;
         gotHnd <= outHandles;
         gotRel <= releaseValid;
         got <= 1'b1;
      end
      if (memReq === 1'b1) begin
         check(memAddr & 32'hFFFF_FF0F, TBL);
      end
      if (cycles == 20000) begin
         fails++;
         finish_test();
      end
   end
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      // Limits are ratios to the viewport half-extent; set 0 is twice the viewport, set 1 half of it.
      u_cgd_mem_model.gbTab[0] = {32'hFFFE_0000, 32'h0002_0000, 32'hFFFE_0000, 32'h0002_0000};
      u_cgd_mem_model.gbTab[1] = {32'hFFFF_8000, I0, 32'hFFFF_8000, I0};
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      rdc(`CGD_REG_CTRL, `CGD_CTRL_RESET, 1'b0);
      rdc(12'h020, 32'h0, 1'b1);
      apb(1'b1, `CGD_REG_TBLPTR, TBL);
      apb(1'b1, `CGD_REG_CTRL, 32'h0000_FF03);
      $display("test registers done");
      obj(2'd3, 4'd0, I0, I0, I0, W1, 8'h00, 1'b0, cgd_pkg::CGD_OUT_ACCEPT);
      obj(2'd3, 4'd0, O1, O1, O1, W1, 8'h00, 1'b0, cgd_pkg::CGD_OUT_REJECT);
      obj(2'd3, 4'd0, I0, O1, O1, W1, 8'h00, 1'b0, cgd_pkg::CGD_OUT_ACCEPT);
      obj(2'd3, 4'd0, I0, F3, F3, W1, 8'h00, 1'b0, cgd_pkg::CGD_OUT_CLIP);
      slow <= 1'b1;
      obj(2'd3, 4'd1, I0, M8, I0, W1, 8'h00, 1'b0, cgd_pkg::CGD_OUT_CLIP);
      obj(2'd2, 4'd0, I0, O1, '0, W1, 8'h00, 1'b0, cgd_pkg::CGD_OUT_ACCEPT);
      obj(2'd2, 4'd0, O1, O1, '0, W1, 8'h00, 1'b0, cgd_pkg::CGD_OUT_REJECT);
      obj(2'd1, 4'd0, I0, '0, '0, WN, 8'h00, 1'b0, cgd_pkg::CGD_OUT_REJECT);
      slow <= 1'b0;
      obj(2'd3, 4'd0, I0, I0, I0, W1, 8'h01, 1'b0, cgd_pkg::CGD_OUT_REJECT);
      $display("test decisions done");
      apb(1'b1, `CGD_REG_CTRL, 32'h0000_0003);
      obj(2'd3, 4'd0, I0, I0, I0, W1, 8'h01, 1'b0, cgd_pkg::CGD_OUT_ACCEPT);
      // Band off, as for wide lines and points: partly visible objects go to a clip thread.
      apb(1'b1, `CGD_REG_CTRL, 32'h0000_0001);
      obj(2'd3, 4'd0, I0, O1, O1, W1, 8'h00, 1'b0, cgd_pkg::CGD_OUT_CLIP);
      apb(1'b1, `CGD_REG_CTRL, 32'h0000_0002);
      obj(2'd3, 4'd0, F3, F3, F3, W1, 8'h00, 1'b0, cgd_pkg::CGD_OUT_REJECT);
      obj(2'd3, 4'd0, O1, O1, O1, W1, 8'h00, 1'b0, cgd_pkg::CGD_OUT_ACCEPT);
      apb(1'b1, `CGD_REG_CTRL, 32'h0000_0007);
      obj(2'd3, 4'd0, O1, O1, O1, W1, 8'h00, 1'b0, cgd_pkg::CGD_OUT_CLIP);
      apb(1'b1, `CGD_REG_CTRL, 32'h0000_000B);
      obj(2'd3, 4'd0, O1, O1, O1, W1, 8'h00, 1'b0, cgd_pkg::CGD_OUT_REJECT);
      obj(2'd3, 4'd0, I0, I0, I0, W1, 8'h00, 1'b0, cgd_pkg::CGD_OUT_CLIP);
      rdc(`CGD_REG_ACCCNT, 32'(nA), 1'b0);
      rdc(`CGD_REG_REJCNT, 32'(nR), 1'b0);
      rdc(`CGD_REG_CLPCNT, 32'(nC), 1'b0);
      $display("test routing and modes done");
      apb(1'b1, `CGD_REG_CTRL, 32'h0000_0003);
      obj(2'd1, 4'd0, F3, '0, '0, W1, 8'h00, 1'b1, cgd_pkg::CGD_OUT_ACCEPT);
      rdc(`CGD_REG_STATUS, 32'h0000_0003, 1'b0);
      apb(1'b1, `CGD_REG_TBLPTR, TBL);
      rdc(`CGD_REG_STATUS, 32'h0000_0000, 1'b0);
      obj(2'd3, 4'd1, I0, I0, I0, W1, 8'h00, 1'b0, cgd_pkg::CGD_OUT_ACCEPT);
      check(u_cgd_mem_model.reads, nV);
      $display("test readback and table done");
      finish_test();
   end
endmodule
`default_nettype wire
